// ### logic/gpoirq_regs.svh
// Purpose: Named offsets, field positions and reset values for the output and polarity block
// Assumes: Register index is a word index inside the block
// Notes:   Included by bare name
`ifndef GPOIRQ_REGS_SVH
`define GPOIRQ_REGS_SVH
`define GPOIRQ_IDX_STATUS_OUT  2'h0
`define GPOIRQ_IDX_UPPER_OUT   2'h1
`define GPOIRQ_IDX_IRQ_LEVEL   2'h2
`define GPOIRQ_IDX_UNUSED      2'h3
`define GPOIRQ_STATUS_PIN_LO   8
`define GPOIRQ_STATUS_PIN_HI   11
`define GPOIRQ_STATUS_PINS     4
`define GPOIRQ_STATUS_W        12
`define GPOIRQ_UPPER_W         8
`define GPOIRQ_DIR_STEP        3
`define GPOIRQ_DIR_BASE        2
`define GPOIRQ_DIR600_LO_BIT   26
`define GPOIRQ_DIR600_HI_BIT   29
`define GPOIRQ_DIR604_LO_BIT   2
`define GPOIRQ_DIR604_HI_BIT   5
`define GPOIRQ_RST_STATUS_OUT  12'h000
`define GPOIRQ_RST_UPPER_OUT   8'h00
`define GPOIRQ_RST_IRQ_LEVEL   12'h000
`endif

// ### logic/gpoirq_pkg.sv
// Purpose: Types shared by the output and polarity block
// Assumes: Nothing beyond the register header
// Notes:   Mode selects where the direction register is reached
package gpoirq_pkg;
  typedef enum logic [1:0] {
    GPOIRQ_MODE_BASE    = 2'b01,
    GPOIRQ_MODE_VSWITCH = 2'b10
  } gpoirq_mode_t;
endpackage

// ### logic/gpoirq_pin_drive.sv
// Purpose: Registered tristate drive for one group of pins, driving either level while enabled
// Assumes: Output enable low means the pin is driven
// Notes:   One flop stage, so a written value reaches the pin on the next edge
`timescale 1ns/1ps
module gpoirq_pin_drive #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] value_i,
  input  wire logic [WIDTH-1:0] dir_out_i,
  output logic      [WIDTH-1:0] pin_o,
  output logic      [WIDTH-1:0] pin_oe_n_o
);
  initial begin
    if (WIDTH < 1) $error("gpoirq_pin_drive: WIDTH must be at least 1");
  end
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_o      <= '0;
      pin_oe_n_o <= '1;
    end else begin
      pin_o      <= value_i;
      pin_oe_n_o <= ~dir_out_i;
    end
  end
endmodule // gpoirq_pin_drive

// ### logic/gpoirq_top.sv
// Purpose: Output data for status lines and upper pins, and interrupt level select
// Assumes: Register port is a simple word-indexed write/read strobe interface
// Notes:   Direction bits arrive as 32-bit register images from their own owners
//
// How it works
// - Output bits 8..11 drive status lines 20..23 only while their direction bits are set.
// - Reading an output data bit returns the last value written, not the pin.
// - Upper pins 24..31 drive only while their direction bit at bits 2,5,..,23 is set.
// - Upper output bits 0..7 map to pins 24..31 in order with no extra staging.
// - Polarity bits 0..11 set the active level of status-line interrupt inputs 0..11.
// - A polarity bit of 0 means active low, 1 means active high.
// - The direction register image is taken by mode: base port or management port.
`timescale 1ns/1ps
`include "gpoirq_regs.svh"
module gpoirq_top
  import gpoirq_pkg::*;
#(
  parameter int STATUS_W = `GPOIRQ_STATUS_W,
  parameter int UPPER_W  = `GPOIRQ_UPPER_W
) (
  input  wire logic                sys_clk_i,
  input  wire logic                arst_n_i,
  input  wire gpoirq_mode_t        mode_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  input  wire logic [1:0]          reg_idx_i,
  input  wire logic [31:0]         reg_wdata_i,
  input  wire logic [31:0]         dir600_base_i,
  input  wire logic [31:0]         dir604_base_i,
  input  wire logic [31:0]         dir60c_base_i,
  input  wire logic [31:0]         dir600_mgmt_i,
  input  wire logic [31:0]         dir604_mgmt_i,
  input  wire logic [31:0]         dir60c_mgmt_i,
  input  wire logic [STATUS_W-1:0] irq_raw_i,
  output logic      [31:0]         reg_rdata_o,
  output logic      [3:0]          status_pin_o,
  output logic      [3:0]          status_pin_oe_n_o,
  output logic      [UPPER_W-1:0]  upper_pin_o,
  output logic      [UPPER_W-1:0]  upper_pin_oe_n_o,
  output logic      [STATUS_W-1:0] irq_active_o
);
  initial begin
    if (STATUS_W != `GPOIRQ_STATUS_W) $error("gpoirq_top: STATUS_W must be 12");
    if (UPPER_W != `GPOIRQ_UPPER_W) $error("gpoirq_top: UPPER_W must be 8");
  end

  // Every third bit from the base position holds a direction flag
  function automatic logic [UPPER_W-1:0] dir_pick(input logic [31:0] img);
    logic [UPPER_W-1:0] r;
    r = '0;
    for (int i = 0; i < UPPER_W; i++) begin
      r[i] = img[`GPOIRQ_DIR_BASE + `GPOIRQ_DIR_STEP * i];
    end
    return r;
  endfunction

  logic [STATUS_W-1:0] status_out_q, status_out_d;
  logic [UPPER_W-1:0]  upper_out_q,  upper_out_d;
  logic [STATUS_W-1:0] irq_level_q,  irq_level_d;
  logic [31:0]         rdata_d;

  wire logic        is_mgmt   = (mode_i == GPOIRQ_MODE_VSWITCH);
  wire logic [31:0] dir600    = is_mgmt ? dir600_mgmt_i : dir600_base_i;
  wire logic [31:0] dir604    = is_mgmt ? dir604_mgmt_i : dir604_base_i;
  wire logic [31:0] dir60c    = is_mgmt ? dir60c_mgmt_i : dir60c_base_i;
  wire logic [3:0]  status_dir = {dir604[`GPOIRQ_DIR604_HI_BIT], dir604[`GPOIRQ_DIR604_LO_BIT],
                                  dir600[`GPOIRQ_DIR600_HI_BIT], dir600[`GPOIRQ_DIR600_LO_BIT]};
  wire logic [UPPER_W-1:0] upper_dir = dir_pick(dir60c);

  wire logic wr_status = reg_wr_i && (reg_idx_i == `GPOIRQ_IDX_STATUS_OUT);
  wire logic wr_upper  = reg_wr_i && (reg_idx_i == `GPOIRQ_IDX_UPPER_OUT);
  wire logic wr_level  = reg_wr_i && (reg_idx_i == `GPOIRQ_IDX_IRQ_LEVEL);

  // Stores happen regardless of direction
  assign status_out_d = wr_status ? reg_wdata_i[STATUS_W-1:0] : status_out_q;
  assign upper_out_d  = wr_upper  ? reg_wdata_i[UPPER_W-1:0]  : upper_out_q;
  assign irq_level_d  = wr_level  ? reg_wdata_i[STATUS_W-1:0] : irq_level_q;

  // Reads show stored values, never pin levels
  assign rdata_d = !reg_rd_i ? 32'h0000_0000 :
    (reg_idx_i == `GPOIRQ_IDX_STATUS_OUT) ? {20'h0_0000, status_out_q} :
    (reg_idx_i == `GPOIRQ_IDX_UPPER_OUT)  ? {24'h00_0000, upper_out_q} :
    (reg_idx_i == `GPOIRQ_IDX_IRQ_LEVEL)  ? {20'h0_0000, irq_level_q} : 32'h0000_0000;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_out_q <= `GPOIRQ_RST_STATUS_OUT;
      upper_out_q  <= `GPOIRQ_RST_UPPER_OUT;
      irq_level_q  <= `GPOIRQ_RST_IRQ_LEVEL;
      reg_rdata_o  <= 32'h0000_0000;
      irq_active_o <= '0;
    end else begin
      status_out_q <= status_out_d;
      upper_out_q  <= upper_out_d;
      irq_level_q  <= irq_level_d;
      reg_rdata_o  <= rdata_d;
      // Xnor: high level matches polarity 1, low level matches 0
      irq_active_o <= ~(irq_raw_i ^ irq_level_q);
    end
  end

  // Pins take the next-state value so a write lands at the same edge as the store
  gpoirq_pin_drive #(.WIDTH(`GPOIRQ_STATUS_PINS)) u_status_drv (
    .sys_clk_i  (sys_clk_i),
    .arst_n_i   (arst_n_i),
    .value_i    (status_out_d[`GPOIRQ_STATUS_PIN_HI:`GPOIRQ_STATUS_PIN_LO]),
    .dir_out_i  (status_dir),
    .pin_o      (status_pin_o),
    .pin_oe_n_o (status_pin_oe_n_o)
  );

  gpoirq_pin_drive #(.WIDTH(UPPER_W)) u_upper_drv (
    .sys_clk_i  (sys_clk_i),
    .arst_n_i   (arst_n_i),
    .value_i    (upper_out_d),
    .dir_out_i  (upper_dir),
    .pin_o      (upper_pin_o),
    .pin_oe_n_o (upper_pin_oe_n_o)
  );

  // Reset guard: the first edge after release still shows the reset enables
  upper_drive_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $past(arst_n_i) |-> upper_pin_oe_n_o == ~$past(upper_dir));
  upper_value_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_upper |=> upper_pin_o == $past(reg_wdata_i[UPPER_W-1:0]));
  status_value_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_status |=>
    status_pin_o == $past(reg_wdata_i[`GPOIRQ_STATUS_PIN_HI:`GPOIRQ_STATUS_PIN_LO]));
  status_drive_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $past(arst_n_i) |-> status_pin_oe_n_o == ~$past(status_dir));
  sequence wr_then_rd_s;
    wr_upper ##1 (reg_rd_i && !reg_wr_i && reg_idx_i == `GPOIRQ_IDX_UPPER_OUT);
  endsequence
  readback_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_then_rd_s |=> reg_rdata_o[UPPER_W-1:0] == $past(reg_wdata_i[UPPER_W-1:0], 2));
  store_hidden_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (wr_upper && upper_dir == '0) |=>
    upper_pin_oe_n_o == '1 && upper_out_q == $past(reg_wdata_i[UPPER_W-1:0]));
  level_high_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (irq_level_q[0] && irq_raw_i[0] && !wr_level) |=> irq_active_o[0]);
  level_low_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (!irq_level_q[11] && !irq_raw_i[11] && !wr_level) |=> irq_active_o[11]);
  mode_pick_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    is_mgmt |=> upper_pin_oe_n_o == ~dir_pick($past(dir60c_mgmt_i)));

  // Read port: idle cycles and index 3 show zero, each other index returns its own store
  rd_idle_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !reg_rd_i |=>
    reg_rdata_o == '0);
  rd_status_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (reg_rd_i && reg_idx_i == `GPOIRQ_IDX_STATUS_OUT) |=>
    reg_rdata_o[STATUS_W-1:0] == $past(status_out_q) && reg_rdata_o[31:STATUS_W] == '0);
  rd_upper_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (reg_rd_i && reg_idx_i == `GPOIRQ_IDX_UPPER_OUT) |=>
    reg_rdata_o[UPPER_W-1:0] == $past(upper_out_q) && reg_rdata_o[31:UPPER_W] == '0);
  rd_level_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (reg_rd_i && reg_idx_i == `GPOIRQ_IDX_IRQ_LEVEL) |=>
    reg_rdata_o[STATUS_W-1:0] == $past(irq_level_q) && reg_rdata_o[31:STATUS_W] == '0);
  rd_unmapped_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (reg_rd_i && reg_idx_i == `GPOIRQ_IDX_UNUSED) |=>
    reg_rdata_o == '0);
  // A read in the write cycle still sees the old word
  rd_old_value_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (reg_rd_i && wr_upper) |=>
    reg_rdata_o[UPPER_W-1:0] == $past(upper_out_q));

  sequence wr_status_then_rd_s;
    wr_status ##1 (reg_rd_i && !reg_wr_i && reg_idx_i == `GPOIRQ_IDX_STATUS_OUT);
  endsequence
  sequence wr_level_then_rd_s;
    wr_level ##1 (reg_rd_i && !reg_wr_i && reg_idx_i == `GPOIRQ_IDX_IRQ_LEVEL);
  endsequence
  status_readback_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_status_then_rd_s |=>
    reg_rdata_o[STATUS_W-1:0] == $past(reg_wdata_i[STATUS_W-1:0], 2));
  level_readback_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_level_then_rd_s |=>
    reg_rdata_o[STATUS_W-1:0] == $past(reg_wdata_i[STATUS_W-1:0], 2));

  // Stores change only on their own write
  upper_hold_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !wr_upper |=>
    upper_out_q == $past(upper_out_q));
  status_hold_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !wr_status |=>
    status_out_q == $past(status_out_q));
  level_hold_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !wr_level |=>
    irq_level_q == $past(irq_level_q));
  level_store_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_level |=>
    irq_level_q == $past(reg_wdata_i[STATUS_W-1:0]));
  status_store_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (wr_status && status_dir == '0) |=>
    status_pin_oe_n_o == '1 && status_out_q == $past(reg_wdata_i[STATUS_W-1:0]));

  // Pins keep the stored value between writes
  status_pin_hold_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !wr_status |=>
    status_pin_o == $past(status_out_q[`GPOIRQ_STATUS_PIN_HI:`GPOIRQ_STATUS_PIN_LO]));
  upper_pin_hold_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !wr_upper |=>
    upper_pin_o == $past(upper_out_q));

  // Each mode must take only its own direction images
  base_pick_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !is_mgmt |=>
    upper_pin_oe_n_o == ~dir_pick($past(dir60c_base_i)));
  status_base_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !is_mgmt |=>
    status_pin_oe_n_o[0] == !$past(dir600_base_i[`GPOIRQ_DIR600_LO_BIT]));
  status_mgmt_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    is_mgmt |=>
    status_pin_oe_n_o[3] == !$past(dir604_mgmt_i[`GPOIRQ_DIR604_HI_BIT]));

  // Active level reports active, inactive level must not
  level_high_off_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (irq_level_q[11] && !irq_raw_i[11]) |=>
    !irq_active_o[11]);
  level_low_off_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (!irq_level_q[0] && irq_raw_i[0]) |=>
    !irq_active_o[0]);
  level_map_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (irq_level_q[4] && irq_raw_i[4]) |=>
    irq_active_o[4]);
endmodule // gpoirq_top

// ### dv/gpoirq_board.sv
// Purpose: Board side of the status lines and upper pins
// Assumes: Pull-ups on every line, as the lines are active low
// Notes:   A released line reads high, never the last driven value
`timescale 1ns/1ps
module gpoirq_board (
  input  wire logic [3:0] status_pin_i,
  input  wire logic [3:0] status_oe_n_i,
  input  wire logic [7:0] upper_pin_i,
  input  wire logic [7:0] upper_oe_n_i,
  output logic      [3:0] status_lvl_o,
  output logic      [7:0] upper_lvl_o
);
  assign status_lvl_o = status_pin_i | status_oe_n_i;
  assign upper_lvl_o  = upper_pin_i | upper_oe_n_i;
endmodule // gpoirq_board

// ### dv/test_gpoirq_top.sv
// Purpose: Self-checking bench for the output and polarity block
// Assumes: Inputs change on the falling edge
// Notes:   Pins and read data are judged one edge after the request
`timescale 1ns/1ps
module test_gpoirq_top;
  import gpoirq_pkg::*;
  logic clk = 0, arst_n = 0, wr = 0, rd = 0;
  gpoirq_mode_t mode = GPOIRQ_MODE_BASE;
  logic [1:0] idx = 2'h0;
  logic [31:0] wd = 0, b600 = 0, b604 = 0, b60c = 0, m600 = 0, m604 = 0, m60c = 0, rdata;
  logic [11:0] raw = 12'h000, act;
  logic [3:0] spin, soe, slvl;
  logic [7:0] upin, uoe, ulvl;
  int error_cnt = 0, tests_run = 0;
  always #2 clk = ~clk;
  gpoirq_top u_gpoirq_top (.sys_clk_i(clk), .arst_n_i(arst_n), .mode_i(mode), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_idx_i(idx), .reg_wdata_i(wd), .dir600_base_i(b600),
    .dir604_base_i(b604), .dir60c_base_i(b60c), .dir600_mgmt_i(m600), .dir604_mgmt_i(m604),
    .dir60c_mgmt_i(m60c), .irq_raw_i(raw), .reg_rdata_o(rdata), .status_pin_o(spin),
    .status_pin_oe_n_o(soe), .upper_pin_o(upin), .upper_pin_oe_n_o(uoe), .irq_active_o(act));
  gpoirq_board u_gpoirq_board (.status_pin_i(spin), .status_oe_n_i(soe), .upper_pin_i(upin),
    .upper_oe_n_i(uoe), .status_lvl_o(slvl), .upper_lvl_o(ulvl));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrt(input logic [1:0] i, input logic [31:0] d);
    @(negedge clk); wr = 1; idx = i; wd = d;
    @(negedge clk); wr = 0;
  endtask
  task automatic rdc(input string n, input logic [1:0] i, input logic [31:0] e);
    @(negedge clk); rd = 1; idx = i;
    @(negedge clk); rd = 0;
    chk(n, e, rdata);
  endtask
  task automatic t_reset;
    rdc("status_out", 2'h0, 32'h0); rdc("upper_out", 2'h1, 32'h0); rdc("level", 2'h2, 32'h0);
    chk("upper_oe", 32'hff, uoe);
    chk("status_oe", 32'hf, soe);
  endtask
  task automatic t_upper;
    for (int k = 0; k < 4; k++) b60c[2+3*k] = 1'b1;
    wrt(2'h1, 32'hffff_ffa5);
    chk("upper_pin", 32'ha5, upin);
    chk("upper_oe", 32'hf0, uoe);
    chk("upper_lvl", 32'hf5, ulvl);
    rdc("upper_out", 2'h1, 32'ha5);
    wrt(2'h1, 32'h5a);
    chk("upper_lvl", 32'hfa, ulvl);
  endtask
  task automatic t_status;
    b600[26] = 1; b600[29] = 1; b604[2] = 1;
    wrt(2'h0, 32'hffff_fa00);
    chk("status_pin", 32'ha, spin);
    chk("status_oe", 32'h8, soe);
    chk("status_lvl", 32'ha, slvl);
    rdc("status_out", 2'h0, 32'ha00);
  endtask
  task automatic t_mode;
    @(negedge clk); mode = GPOIRQ_MODE_VSWITCH;
    @(negedge clk);
    chk("upper_oe", 32'hff, uoe);
    m60c = 32'hffff_ffff;
    m604[5] = 1;
    @(negedge clk);
    chk("upper_oe", 32'h0, uoe);
    chk("status_oe", 32'h7, soe);
  endtask
  task automatic t_irq;
    wrt(2'h2, 32'hffff_fabc); raw = 12'ha0f;
    @(negedge clk);
    chk("irq_active", 32'hf4c, act);
    rdc("level", 2'h2, 32'habc);
    wrt(2'h3, 32'h1234);
    rdc("unmapped", 2'h3, 32'h0);
    wrt(2'h2, 32'h0000_0f11);
    raw = 12'h011;
    @(negedge clk);
    chk("irq_active", 32'h0ff, act);
  endtask
  task automatic t_rst2;
    wrt(2'h1, 32'h3c);
    @(negedge clk);
    arst_n = 0;
    @(negedge clk);
    chk("upper_oe", 32'hff, uoe);
    arst_n = 1;
    rdc("upper_out", 2'h1, 32'h0);
    chk("upper_pin", 32'h0, upin);
    chk("upper_oe", 32'h0, uoe);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    arst_n = 1;
    t_reset;
    t_upper;
    t_status;
    t_mode;
    t_irq;
    t_rst2;
    summarize;
  end
  initial begin
    #4000;
    error_cnt++;
    summarize;
  end
endmodule // test_gpoirq_top
